// ---- ioag_pkg.sv ----
// package for the indexed offset address generator
// assumes a 100 MHz core clock and an avalon-mm register bus
package ioag_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PTR0 = 5'h04;
  localparam logic [4:0] OFS_PTR1 = 5'h08;
  localparam logic [4:0] OFS_PTR2 = 5'h0c;
  localparam logic [4:0] OFS_BANK = 5'h10;
  localparam logic [4:0] OFS_CMD = 5'h14;
  localparam logic [4:0] OFS_RESULT = 5'h18;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int CTRL_EXT_BIT = 0;
  localparam int PTR_W = 12;
  localparam int BANK_W = 4;
  localparam int CMD_W = 18;
  localparam int CMD_CLASS_LSB = 16;
  localparam int INSTR_DEST_BIT = 9;
  localparam int INSTR_ACC_BIT = 8;
  localparam int RES_MODE_LSB = 12;
  localparam int RES_DEST_BIT = 16;
  localparam int RES_ADDW_BIT = 17;
  localparam int RES_SEEN_BIT = 18;

  // ----------------------------------------
  // decode constants
  // ----------------------------------------
  localparam logic [5:0] ADDW_OPCODE = 6'h09;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [7:0] STD_ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] SFR_BANK = 4'hf;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [1:0] CLS_AUTO = 2'h0;
  localparam logic [1:0] CLS_FILE = 2'h1;
  localparam logic [1:0] CLS_INDIRECT = 2'h2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_EXT = 1'b0;
  localparam logic [PTR_W-1:0] RST_PTR = 12'h000;
  localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
  localparam logic [CMD_W-1:0] RST_CMD = 18'h00000;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_INDEXED,
    MODE_FORCED,
    MODE_LONG,
    MODE_INDIRECT
  } ioag_mode_t;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    ioag_mode_t mode;
    logic dest_file;
    logic add_w_to_file;
  } ioag_result_t;

endpackage : ioag_pkg

// ---- ioag_addr_gen.sv ----
// data memory effective address generator with avalon-mm register slave
// assumes a synchronous bus master that holds requests until waitrequest low
//
// Contract
// - indexed offset only when extended set enabled
// - a=0, f<=5Fh: pointer pair two plus f
// - a=0, f>=60h extended: forced onto F60h upward
// - no forced path below 60h when extended
// - a=1: bank select value picks bank
// - inherent and literal instructions stay unaffected
// - indirect accesses keep standard pointer behaviour
// - memory size and register map unchanged
// - decode add_w_to_file from 0010 01da ffffffff
// - destination bit routes result, one means file
// - long address is bank value then f
// - each pointer pair holds 12 bits
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module ioag_addr_gen (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output ioag_pkg::ioag_result_t result,
  output logic result_valid,
  output logic extended_set_enable
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] lanes
  );
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        merged[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return merged;
  endfunction : merge_bytes

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait cycle per access keeps readdata a clean flop output
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic rd_sample;
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;
  assign wr_take = avs_write & ~avs_waitrequest;
  assign rd_sample = avs_read & avs_waitrequest;

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic hit_ctrl;
  logic hit_bank;
  logic hit_cmd;
  logic hit_result;
  logic [2:0] hit_ptr;
  assign hit_ctrl = avs_address == ioag_pkg::OFS_CTRL;
  assign hit_bank = avs_address == ioag_pkg::OFS_BANK;
  assign hit_cmd = avs_address == ioag_pkg::OFS_CMD;
  assign hit_result = avs_address == ioag_pkg::OFS_RESULT;
  assign hit_ptr[0] = avs_address == ioag_pkg::OFS_PTR0;
  assign hit_ptr[1] = avs_address == ioag_pkg::OFS_PTR1;
  assign hit_ptr[2] = avs_address == ioag_pkg::OFS_PTR2;

  // ----------------------------------------
  // configuration and pointer registers
  // ----------------------------------------
  logic [31:0] ctrl_merge;
  logic [31:0] bank_merge;
  logic [ioag_pkg::BANK_W-1:0] bank_select_value;
  assign ctrl_merge = merge_bytes({31'h0, extended_set_enable}, avs_writedata, avs_byteenable);
  assign bank_merge = merge_bytes({28'h0, bank_select_value}, avs_writedata, avs_byteenable);

  always_ff @(posedge mclk) begin
    if (rst) begin
      extended_set_enable <= ioag_pkg::RST_EXT;
    end else if (wr_take & hit_ctrl) begin
      extended_set_enable <= ctrl_merge[ioag_pkg::CTRL_EXT_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_select_value <= ioag_pkg::RST_BANK;
    end else if (wr_take & hit_bank) begin
      bank_select_value <= bank_merge[ioag_pkg::BANK_W-1:0];
    end
  end

  // upper four bits of each pair do not exist
  logic [ioag_pkg::PTR_W-1:0] ptr [3];
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_ptr
      logic [31:0] ptr_merge;
      assign ptr_merge = merge_bytes({20'h0, ptr[gp]}, avs_writedata, avs_byteenable);
      always_ff @(posedge mclk) begin
        if (rst) begin
          ptr[gp] <= ioag_pkg::RST_PTR;
        end else if (wr_take & hit_ptr[gp]) begin
          ptr[gp] <= ptr_merge[ioag_pkg::PTR_W-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // command register
  // ----------------------------------------
  // a command write launches one decode on the following edge
  logic [ioag_pkg::CMD_W-1:0] cmd;
  logic [31:0] cmd_merge;
  logic cmd_pending;
  assign cmd_merge = merge_bytes({14'h0, cmd}, avs_writedata, avs_byteenable);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd <= ioag_pkg::RST_CMD;
      cmd_pending <= 1'b0;
    end else begin
      cmd_pending <= wr_take & hit_cmd;
      if (wr_take & hit_cmd) begin
        cmd <= cmd_merge[ioag_pkg::CMD_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // instruction fields
  // ----------------------------------------
  logic [15:0] instr;
  logic [1:0] cmd_class;
  logic [7:0] file_field;
  logic acc_bit;
  logic dest_bit;
  logic [1:0] ind_sel;
  assign instr = cmd[15:0];
  assign cmd_class = cmd[ioag_pkg::CMD_CLASS_LSB +: 2];
  assign file_field = instr[7:0];
  assign acc_bit = instr[ioag_pkg::INSTR_ACC_BIT];
  assign dest_bit = instr[ioag_pkg::INSTR_DEST_BIT];
  assign ind_sel = instr[1:0];

  logic is_add_w;
  logic file_op;
  logic ind_op;
  assign is_add_w = instr[15:10] == ioag_pkg::ADDW_OPCODE;
  // anything else under auto class is inherent or literal
  assign file_op = (cmd_class == ioag_pkg::CLS_FILE) |
                   ((cmd_class == ioag_pkg::CLS_AUTO) & is_add_w);
  assign ind_op = (cmd_class == ioag_pkg::CLS_INDIRECT) & (ind_sel != 2'h3);

  // ----------------------------------------
  // address modes
  // ----------------------------------------
  logic indexed_hit;
  logic std_low;
  logic [ioag_pkg::PTR_W-1:0] indexed_addr;
  logic [ioag_pkg::PTR_W-1:0] forced_addr;
  logic [ioag_pkg::PTR_W-1:0] long_addr;
  logic [ioag_pkg::PTR_W-1:0] ind_addr;

  // extended set alone opens the indexed window
  assign indexed_hit = extended_set_enable & ~acc_bit &
                       (file_field <= ioag_pkg::INDEXED_MAX);
  // sum cut to 12 bits; pointer pair two is also read by the indirect path and by read back
  assign indexed_addr = ptr[2] + {4'h0, file_field};
  // standard access bank split; extended forced values are all above 5Fh
  assign std_low = ~extended_set_enable & (file_field < ioag_pkg::STD_ACCESS_SPLIT);
  assign forced_addr = {(std_low ? ioag_pkg::LOW_BANK : ioag_pkg::SFR_BANK),
                        file_field};
  assign long_addr = {bank_select_value, file_field};
  // indirect pairs never see the offset, pair two included
  assign ind_addr = ptr[ind_sel];

  // ----------------------------------------
  // result selection
  // ----------------------------------------
  ioag_pkg::ioag_result_t next_result;
  always_comb begin
    next_result = '0;
    next_result.mode = ioag_pkg::MODE_NONE;
    next_result.add_w_to_file = is_add_w & (cmd_class == ioag_pkg::CLS_AUTO);
    if (file_op) begin
      next_result.dest_file = dest_bit;
      if (acc_bit) begin
        next_result.mode = ioag_pkg::MODE_LONG;
        next_result.addr = long_addr;
      end else if (indexed_hit) begin
        next_result.mode = ioag_pkg::MODE_INDEXED;
        next_result.addr = indexed_addr;
      end else begin
        next_result.mode = ioag_pkg::MODE_FORCED;
        next_result.addr = forced_addr;
      end
    end else if (ind_op) begin
      next_result.mode = ioag_pkg::MODE_INDIRECT;
      next_result.addr = ind_addr;
    end
  end

  logic result_seen;
  always_ff @(posedge mclk) begin
    if (rst) begin
      result <= '0;
      result_valid <= 1'b0;
      result_seen <= 1'b0;
    end else begin
      result_valid <= cmd_pending;
      if (cmd_pending) begin
        result <= next_result;
        result_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  logic [31:0] result_word;
  logic [31:0] next_readdata;
  assign result_word = {13'h0, result_seen, result.add_w_to_file, result.dest_file,
                        1'b0, 3'(result.mode), result.addr};

  always_comb begin
    next_readdata = 32'h0;
    case (1'b1)
      hit_ctrl: next_readdata = {31'h0, extended_set_enable};
      hit_ptr[0]: next_readdata = {20'h0, ptr[0]};
      hit_ptr[1]: next_readdata = {20'h0, ptr[1]};
      hit_ptr[2]: next_readdata = {20'h0, ptr[2]};
      hit_bank: next_readdata = {28'h0, bank_select_value};
      hit_cmd: next_readdata = {14'h0, cmd};
      hit_result: next_readdata = result_word;
      default: next_readdata = 32'h0;
    endcase
  end

  // unmapped reads answer zero, unmapped writes are dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_sample) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule : ioag_addr_gen

// ---- ioag_bus_monitor.sv ----
// checker: decode relations of the address generator
// assumes full byte enables on mirrored register writes
`timescale 1ns/10ps
module ioag_bus_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire ioag_pkg::ioag_result_t result,
  input wire logic result_valid,
  input wire logic extended_set_enable
);
  // ------
  // register mirrors
  // ------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic [11:0] ptr [3];
  logic [3:0] bank;
  logic [17:0] cmd_q;
  wire take = avs_write && !avs_waitrequest;
  wire [7:0] f = cmd_q[7:0];
  wire auto_c = cmd_q[17:16] == ioag_pkg::CLS_AUTO;
  wire file_op = cmd_q[17:16] == ioag_pkg::CLS_FILE
    || (auto_c && cmd_q[15:10] == ioag_pkg::ADDW_OPCODE);
  wire a0 = result_valid && file_op && !cmd_q[8];
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr <= '{default: 12'h000};
      bank <= 4'h0;
      cmd_q <= 18'h00000;
    end else if (take) begin
      for (int i = 0; i < 3; i++) begin
        if (avs_address == 5'(4 * i + 4)) ptr[i] <= avs_writedata[11:0];
      end
      if (avs_address == ioag_pkg::OFS_BANK) bank <= avs_writedata[3:0];
      if (avs_address == ioag_pkg::OFS_CMD) cmd_q <= avs_writedata[17:0];
    end
  end
  sequence s_take_cmd;
    take && avs_address == ioag_pkg::OFS_CMD;
  endsequence
  sequence s_pulse;
    result_valid ##1 !result_valid;
  endsequence
  // command stored at the accept edge, pulse launched one edge later
  AST_DECODE_PULSE: assert property (s_take_cmd |-> ##2 s_pulse)
    else $error("decode pulse");
  AST_LONG: assert property (result_valid && file_op && cmd_q[8] |->
    result.mode == ioag_pkg::MODE_LONG && result.addr == {bank, f}) else $error("long");
  AST_INDEXED: assert property (a0 && extended_set_enable && f <= 8'h5f |->
    result.mode == ioag_pkg::MODE_INDEXED && result.addr == ptr[2] + {4'h0, f})
    else $error("indexed");
  AST_FORCED: assert property (a0 && extended_set_enable && f >= 8'h60 |->
    result.mode == ioag_pkg::MODE_FORCED && result.addr == {4'hf, f}) else $error("forced");
  AST_STANDARD: assert property (a0 && !extended_set_enable |->
    result.mode != ioag_pkg::MODE_INDEXED && result.addr == {f[7] ? 4'hf : 4'h0, f})
    else $error("standard");
  AST_DEST: assert property (result_valid && file_op |->
    result.dest_file == cmd_q[9] && result.add_w_to_file == auto_c) else $error("dest");
  AST_INHERENT: assert property (result_valid && auto_c && !file_op |->
    result.mode == ioag_pkg::MODE_NONE && result.addr == 12'h000) else $error("inherent");
  AST_INDIRECT: assert property (result_valid && cmd_q[17:16] == ioag_pkg::CLS_INDIRECT
    && cmd_q[1:0] != 2'h3 |-> result.mode == ioag_pkg::MODE_INDIRECT
    && result.addr == ptr[cmd_q[1:0]]) else $error("indirect");
  AST_EXT_COPY: assert property (take && avs_byteenable[0]
    && avs_address == ioag_pkg::OFS_CTRL |=> extended_set_enable == $past(avs_writedata[0]))
    else $error("ext copy");
  AST_READ_PTR2: assert property (avs_read && !avs_waitrequest
    && avs_address == ioag_pkg::OFS_PTR2 |-> avs_readdata == {20'h0, ptr[2]})
    else $error("pointer two read back");
endmodule : ioag_bus_monitor

// ---- ioag_dmem_model.sv ----
// far-side data memory stub: latches each decoded address
// assumes result_valid is a one-cycle pulse
`timescale 1ns/10ps
module ioag_dmem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire ioag_pkg::ioag_result_t result,
  input wire logic result_valid,
  output logic [11:0] last_addr
);
  always @(posedge mclk) begin
    if (rst) begin
      last_addr <= 12'h000;
    end else if (result_valid) begin
      last_addr <= result.addr;
    end
  end
endmodule : ioag_dmem_model

// ---- test_indexed_offset_address_gen.sv ----
// bench: bus accesses and decodes, both extension settings
// assumes bus tasks wait for waitrequest low and result follows each command
`timescale 1ns/10ps
module test_indexed_offset_address_gen;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat, got;
  logic wreq, rv, ext;
  logic [11:0] mem_addr;
  ioag_pkg::ioag_result_t res, e;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [11:0] pv [3] = '{12'h123, 12'h456, 12'hfc0};
  logic [17:0] cmds [13] = '{18'h10000, 18'h1025f, 18'h10060, 18'h1007f, 18'h10080,
    18'h10310, 18'h02610, 18'h02522, 18'h00e55, 18'h20000, 18'h20001, 18'h20002,
    18'h20003};
  ioag_addr_gen dut_u (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .result(res), .result_valid(rv), .extended_set_enable(ext));
  ioag_dmem_model mem_u (.mclk(mclk), .rst(rst), .result(res), .result_valid(rv),
    .last_addr(mem_addr));
  always #5 mclk = ~mclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // waitrequest and readdata are read as sampled at the rising edge
    do @(posedge mclk); while (wreq !== 1'b0);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  function automatic ioag_pkg::ioag_result_t exp_res(input logic x, input logic [17:0] c);
    ioag_pkg::ioag_result_t r;
    r = '0;
    if (c[17:16] == 2'h1 || (c[17:16] == 2'h0 && c[15:10] == 6'h09)) begin
      r.dest_file = c[9];
      r.add_w_to_file = c[17:16] == 2'h0;
      r.mode = c[8] ? ioag_pkg::MODE_LONG : ioag_pkg::MODE_FORCED;
      r.addr = {c[8] ? 4'h5 : ((x || c[7]) ? 4'hf : 4'h0), c[7:0]};
      if (x && !c[8] && c[7:0] <= 8'h5f) begin
        r.mode = ioag_pkg::MODE_INDEXED;
        r.addr = pv[2] + {4'h0, c[7:0]};
      end
    end else if (c[17:16] == 2'h2 && c[1:0] != 2'h3) begin
      r.mode = ioag_pkg::MODE_INDIRECT;
      r.addr = pv[c[1:0]];
    end
    return r;
  endfunction : exp_res
  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // hang guard, well above the fewer than two hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, ioag_pkg::OFS_PTR2, 32'h0);
    chk(got, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 5'(4 * i + 4), {20'hfffff, pv[i]});
    end
    bus(1'b1, ioag_pkg::OFS_BANK, 32'h5);
    bus(1'b0, ioag_pkg::OFS_PTR2, 32'h0);
    chk(got, {20'h0, pv[2]});
    bus(1'b0, 5'h1c, 32'h0);
    chk(got, 32'h0);
    for (int x = 0; x < 2; x++) begin
      bus(1'b1, ioag_pkg::OFS_CTRL, 32'(x));
      @(negedge mclk);
      chk(32'(ext), 32'(x));
      foreach (cmds[k]) begin
        e = exp_res(x[0], cmds[k]);
        bus(1'b1, ioag_pkg::OFS_CMD, {14'h0, cmds[k]});
        repeat (2) @(negedge mclk);
        chk(32'(rv), 32'h1);
        chk(32'(res), 32'(e));
        @(negedge mclk);
        chk(32'(rv), 32'h0);
        chk(32'(mem_addr), 32'(e.addr));
      end
    end
    bus(1'b0, ioag_pkg::OFS_RESULT, 32'h0);
    chk(got, 32'h00040000);
    bus(1'b0, ioag_pkg::OFS_PTR2, 32'h0);
    chk(got, {20'h0, pv[2]});
    report_and_stop();
  end
endmodule : test_indexed_offset_address_gen
bind ioag_addr_gen ioag_bus_monitor chk_u (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .result(result), .result_valid(result_valid),
  .extended_set_enable(extended_set_enable));
